/* File: tdmsa_slot_access.sv */
// Purpose: Four slot buffers looping, shifting and monitoring slots of the serial frame
// Assumes: Bit clock, frame sync and lines are asynchronous and slow against sys_clk_i
// Notes:   Registers over AXI4-Lite; one write and one read in flight at most
`timescale 1ns/1ns
`include "tdmsa_cfg.svh"
module tdmsa_slot_access #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr_i,
    input  wire logic                 s_axi_awvalid_i,
    output logic                      s_axi_awready_o,
    input  wire logic [31:0]          s_axi_wdata_i,
    input  wire logic [3:0]           s_axi_wstrb_i,
    input  wire logic                 s_axi_wvalid_i,
    output logic                      s_axi_wready_o,
    output tdmsa_pkg::tdmsa_resp_t    s_axi_bresp_o,
    output logic                      s_axi_bvalid_o,
    input  wire logic                 s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]    s_axi_araddr_i,
    input  wire logic                 s_axi_arvalid_i,
    output logic                      s_axi_arready_o,
    output logic [31:0]               s_axi_rdata_o,
    output tdmsa_pkg::tdmsa_resp_t    s_axi_rresp_o,
    output logic                      s_axi_rvalid_o,
    input  wire logic                 s_axi_rready_i,
    // Serial frame
    input  wire logic                 bit_clock_i,
    input  wire logic                 frame_sync_i,
    input  wire logic                 upstream_line_i,
    input  wire logic                 downstream_line_i,
    output logic                      upstream_line_o,
    output logic                      upstream_line_oe_n_o,
    output logic                      downstream_line_o,
    output logic                      downstream_line_oe_n_o,
    // Event summary
    output logic                      sync_irq_o
);
    // Bit position of a slot offset, wrapped into the frame
    function automatic tdmsa_pkg::tdmsa_pos_t f_wrap(input logic [7:0] v);
        logic [7:0] w;
        w = (v >= 8'(`TDMSA_FRAME_BITS)) ? v - 8'(`TDMSA_FRAME_BITS) : v;
        return w[6:0];
    endfunction

    // Input line and slot of a buffer: {line, slot}
    function automatic logic [4:0] f_in_sel(input logic [7:0] own, input logic [7:0] peer,
                                            input logic xch, input logic arb, input logic even);
        logic [7:0] s;
        s = xch ? peer : own;
        if (even && arb && s[3:0] == `TDMSA_ARB_CODE) begin
            return {s[`TDMSA_SEL_LINE], `TDMSA_ARB_SLOT};
        end
        return {s[`TDMSA_SEL_LINE], s[3:0]};
    endfunction

    // Synchronisers; index 0 is the first stage
    logic [2:0] bclk_s;
    logic [2:0] fsc_s;
    logic [1:0] up_s;
    logic [1:0] dn_s;
    logic       bclk_rise;
    logic       bclk_fall;
    logic       fsc_rise;

    // Core state
    tdmsa_pkg::tdmsa_byte_t data [4];
    tdmsa_pkg::tdmsa_byte_t sel [4];
    tdmsa_pkg::tdmsa_byte_t shreg [4];
    tdmsa_pkg::tdmsa_byte_t outsh [4];
    logic [5:0]             ctrl [2];
    tdmsa_pkg::tdmsa_byte_t mask;
    tdmsa_pkg::tdmsa_byte_t stat;
    logic [3:0]             pend;
    tdmsa_pkg::tdmsa_pos_t  pos;
    logic                   fsc_seen;
    tdmsa_pkg::tdmsa_byte_t next_data [4];
    tdmsa_pkg::tdmsa_byte_t next_sel [4];
    tdmsa_pkg::tdmsa_byte_t next_shreg [4];
    tdmsa_pkg::tdmsa_byte_t next_outsh [4];
    logic [5:0]             next_ctrl [2];
    tdmsa_pkg::tdmsa_byte_t next_mask;
    tdmsa_pkg::tdmsa_byte_t next_stat;
    logic [3:0]             next_pend;
    tdmsa_pkg::tdmsa_pos_t  next_pos;
    logic                   next_fsc_seen;
    logic                   next_up_o;
    logic                   next_up_oe_n;
    logic                   next_dn_o;
    logic                   next_dn_oe_n;
    logic [3:0]             commit;
    logic [3:0]             ov_src;
    logic [3:0]             in_en;
    logic [3:0]             out_en;

    // Register write strobe from the bus group
    logic                   wr_en;
    logic [ADDR_W-1:0]      wr_addr;
    tdmsa_pkg::tdmsa_byte_t wr_byte;

    assign bclk_rise = bclk_s[1] & ~bclk_s[2];
    assign bclk_fall = ~bclk_s[1] & bclk_s[2];
    assign fsc_rise  = fsc_s[1] & ~fsc_s[2];

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            in_en[2*p]    = ctrl[p][`TDMSA_CTRL_IN0];
            out_en[2*p]   = ctrl[p][`TDMSA_CTRL_OUT0];
            in_en[2*p+1]  = ctrl[p][`TDMSA_CTRL_IN1];
            out_en[2*p+1] = ctrl[p][`TDMSA_CTRL_OUT1];
        end
    end

    always_comb begin
        logic [4:0] isel;
        logic [7:0] base;
        logic [7:0] dly;
        logic       drv_up;
        logic       drv_dn;
        logic       bit_up;
        logic       bit_dn;
        logic [3:0] srcs;
        isel = 5'h00;
        base = 8'h00;
        dly = 8'h00;
        drv_up = 1'b0;
        drv_dn = 1'b0;
        bit_up = 1'b1;
        bit_dn = 1'b1;
        srcs = 4'h0;
        next_data = data;
        next_sel = sel;
        next_shreg = shreg;
        next_outsh = outsh;
        next_ctrl = ctrl;
        next_mask = mask;
        next_stat = stat;
        next_pend = pend;
        next_pos = pos;
        next_fsc_seen = fsc_seen | fsc_rise;
        next_up_o = upstream_line_o;
        next_up_oe_n = upstream_line_oe_n_o;
        next_dn_o = downstream_line_o;
        next_dn_oe_n = downstream_line_oe_n_o;
        commit = 4'h0;
        ov_src = 4'h0;
        // Software writes first, so hardware events in the same cycle win
        if (wr_en) begin
            for (int i = 0; i < 4; i++) begin
                if (wr_addr == ADDR_W'(`TDMSA_OFS_DATA0 + 4 * i)) next_data[i] = wr_byte;
                if (wr_addr == ADDR_W'(`TDMSA_OFS_SEL0 + 4 * i)) next_sel[i] = wr_byte;
            end
            if (wr_addr == ADDR_W'(`TDMSA_OFS_CTRL0)) next_ctrl[0] = wr_byte[5:0];
            if (wr_addr == ADDR_W'(`TDMSA_OFS_CTRL1)) next_ctrl[1] = wr_byte[5:0];
            if (wr_addr == ADDR_W'(`TDMSA_OFS_MASK)) next_mask = wr_byte;
            if (wr_addr == ADDR_W'(`TDMSA_OFS_ACK)) next_pend = pend & ~wr_byte[3:0];
            if (wr_addr == ADDR_W'(`TDMSA_OFS_STAT)) next_stat = stat & ~wr_byte;
        end
        // Bits are sampled on the falling bit clock edge
        if (bclk_fall) begin
            for (int i = 0; i < 4; i++) begin
                isel = f_in_sel(sel[i], sel[i^1], ctrl[i/2][`TDMSA_CTRL_XCH],
                                ctrl[i/2][`TDMSA_CTRL_ARB], (i % 2) == 0);
                if (in_en[i] && pos[6:3] == isel[3:0]) begin
                    next_shreg[i] = {shreg[i][6:0],
                                     isel[4] ? dn_s[1] : up_s[1]};
                end
            end
        end
        // Bit clock counts bit periods; a double-rate clock is not needed
        if (bclk_rise) begin
            next_fsc_seen = fsc_rise;
            if (fsc_seen) next_pos = 7'h00;
            else if (pos == `TDMSA_LAST_POS) next_pos = 7'h00;
            else next_pos = pos + 7'h01;
            for (int i = 0; i < 4; i++) begin
                isel = f_in_sel(sel[i], sel[i^1], ctrl[i/2][`TDMSA_CTRL_XCH],
                                ctrl[i/2][`TDMSA_CTRL_ARB], (i % 2) == 0);
                base = {1'b0, isel[3:0], 3'b000};
                dly = isel[4] ? 8'h01 : 8'h02;
                // Commit late so a slot right after the source goes out next frame
                if (next_pos == f_wrap(base + 8'h07 + dly) && in_en[i]) begin
                    commit[i] = 1'b1;
                    next_data[i] = shreg[i];
                    if (mask[i]) begin
                        next_stat[i] = 1'b1;
                        next_pend[i] = 1'b1;
                    end
                end
                if (next_pos == f_wrap(base + 8'(`TDMSA_FRAME_BITS) - dly) && pend[i]) begin
                    ov_src[i] = 1'b1;
                    next_pend[i] = commit[i];
                end
                // Output slot always from own selection
                if (out_en[i] && next_pos[6:3] == sel[i][3:0]) begin
                    if (next_pos[2:0] == 3'h0) begin
                        next_outsh[i] = {data[i][6:0], 1'b0};
                    end else begin
                        next_outsh[i] = {outsh[i][6:0], 1'b0};
                    end
                    if (sel[i][`TDMSA_SEL_LINE]) begin
                        drv_up = 1'b1;
                        bit_up = (next_pos[2:0] == 3'h0) ? data[i][7] : outsh[i][7];
                    end else begin
                        drv_dn = 1'b1;
                        bit_dn = (next_pos[2:0] == 3'h0) ? data[i][7] : outsh[i][7];
                    end
                end
            end
            for (int j = 0; j < 4; j++) begin
                srcs = mask[j] ? (4'h1 << j) : (ov_src & mask[3:0]);
                if (mask[4+j] && out_en[j] && |(ov_src & srcs)) begin
                    next_stat[4+j] = 1'b1;
                end
            end
            next_up_o = bit_up;
            next_up_oe_n = ~drv_up;
            next_dn_o = bit_dn;
            next_dn_oe_n = ~drv_dn;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        bclk_s <= {bclk_s[1:0], bit_clock_i};
        fsc_s <= {fsc_s[1:0], frame_sync_i};
        up_s <= {up_s[0], upstream_line_i};
        dn_s <= {dn_s[0], downstream_line_i};
        if (!rst_n_i) begin
            for (int i = 0; i < 4; i++) begin
                data[i] <= `TDMSA_RST_BYTE;
                sel[i] <= `TDMSA_RST_ZERO;
                shreg[i] <= `TDMSA_RST_BYTE;
                outsh[i] <= `TDMSA_RST_BYTE;
            end
            ctrl[0] <= 6'h00;
            ctrl[1] <= 6'h00;
            mask <= `TDMSA_RST_ZERO;
            stat <= `TDMSA_RST_ZERO;
            pend <= 4'h0;
            pos <= 7'h00;
            fsc_seen <= 1'b0;
            upstream_line_o <= 1'b1;
            upstream_line_oe_n_o <= 1'b1;
            downstream_line_o <= 1'b1;
            downstream_line_oe_n_o <= 1'b1;
            sync_irq_o <= 1'b0;
        end else begin
            data <= next_data;
            sel <= next_sel;
            shreg <= next_shreg;
            outsh <= next_outsh;
            ctrl <= next_ctrl;
            mask <= next_mask;
            stat <= next_stat;
            pend <= next_pend;
            pos <= next_pos;
            fsc_seen <= next_fsc_seen;
            upstream_line_o <= next_up_o;
            upstream_line_oe_n_o <= next_up_oe_n;
            downstream_line_o <= next_dn_o;
            downstream_line_oe_n_o <= next_dn_oe_n;
            sync_irq_o <= |next_stat;
        end
    end

    // Bus slave: address and data held until both are in
    logic              aw_hold;
    logic              w_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic              w_lane0;
    logic              next_aw_hold;
    logic              next_w_hold;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [31:0]       next_w_data;
    logic              next_w_lane0;
    logic              next_bvalid;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic              hit;
    tdmsa_pkg::tdmsa_resp_t next_bresp;
    tdmsa_pkg::tdmsa_resp_t next_rresp;

    function automatic logic f_mapped(input logic [ADDR_W-1:0] a);
        return a[1:0] == 2'b00 && a <= ADDR_W'(`TDMSA_OFS_POS);
    endfunction

    always_comb begin
        next_aw_hold = aw_hold | (s_axi_awvalid_i & s_axi_awready_o);
        next_w_hold = w_hold | (s_axi_wvalid_i & s_axi_wready_o);
        next_aw_addr = (s_axi_awvalid_i & s_axi_awready_o) ? s_axi_awaddr_i : aw_addr;
        next_w_data = (s_axi_wvalid_i & s_axi_wready_o) ? s_axi_wdata_i : w_data;
        next_w_lane0 = (s_axi_wvalid_i & s_axi_wready_o) ? s_axi_wstrb_i[0] : w_lane0;
        next_bvalid = s_axi_bvalid_o & ~s_axi_bready_i;
        next_bresp = s_axi_bresp_o;
        wr_en = 1'b0;
        wr_addr = aw_addr;
        wr_byte = w_data[7:0];
        if (aw_hold && w_hold && !s_axi_bvalid_o) begin
            wr_en = w_lane0 && f_mapped(aw_addr);
            next_bresp = f_mapped(aw_addr) ? tdmsa_pkg::TDMSA_RESP_OKAY
                                           : tdmsa_pkg::TDMSA_RESP_SLVERR;
            next_bvalid = 1'b1;
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
        end
        next_rvalid = s_axi_rvalid_o & ~s_axi_rready_i;
        next_rdata = s_axi_rdata_o;
        next_rresp = s_axi_rresp_o;
        hit = 1'b0;
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            next_rvalid = 1'b1;
            next_rdata = 32'h0000_0000;
            for (int i = 0; i < 4; i++) begin
                if (s_axi_araddr_i == ADDR_W'(`TDMSA_OFS_DATA0 + 4 * i)) next_rdata[7:0] = data[i];
                if (s_axi_araddr_i == ADDR_W'(`TDMSA_OFS_SEL0 + 4 * i)) next_rdata[7:0] = sel[i];
            end
            if (s_axi_araddr_i == ADDR_W'(`TDMSA_OFS_CTRL0)) next_rdata[5:0] = ctrl[0];
            if (s_axi_araddr_i == ADDR_W'(`TDMSA_OFS_CTRL1)) next_rdata[5:0] = ctrl[1];
            if (s_axi_araddr_i == ADDR_W'(`TDMSA_OFS_MASK)) next_rdata[7:0] = mask;
            if (s_axi_araddr_i == ADDR_W'(`TDMSA_OFS_ACK)) next_rdata[3:0] = pend;
            if (s_axi_araddr_i == ADDR_W'(`TDMSA_OFS_STAT)) next_rdata[7:0] = stat;
            if (s_axi_araddr_i == ADDR_W'(`TDMSA_OFS_POS)) next_rdata[6:0] = pos;
            hit = f_mapped(s_axi_araddr_i);
            next_rresp = hit ? tdmsa_pkg::TDMSA_RESP_OKAY : tdmsa_pkg::TDMSA_RESP_SLVERR;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_lane0 <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= tdmsa_pkg::TDMSA_RESP_OKAY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= tdmsa_pkg::TDMSA_RESP_OKAY;
        end else begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            s_axi_awready_o <= ~next_aw_hold & ~next_bvalid;
            s_axi_wready_o <= ~next_w_hold & ~next_bvalid;
            s_axi_bvalid_o <= next_bvalid;
            s_axi_bresp_o <= next_bresp;
            s_axi_arready_o <= ~next_rvalid;
            s_axi_rvalid_o <= next_rvalid;
            s_axi_rdata_o <= next_rdata;
            s_axi_rresp_o <= next_rresp;
        end
    end

    // Checks
    sequence s_bit_tick;
        bclk_rise;
    endsequence

    a_frame_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (fsc_seen && !fsc_rise) ##0 s_bit_tick |=> pos == 7'h00)
        else $error("Frame sync did not restart the bit position");
    a_pos_range: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        pos <= `TDMSA_LAST_POS)
        else $error("Bit position left the frame");
    a_no_sti_no_stov: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (mask[3:0] == 4'h0 && $stable(mask)) |=> (stat[7:4] & ~$past(stat[7:4])) == 4'h0)
        else $error("Overflow raised with no transfer event enabled");

    for (genvar g = 0; g < 4; g++) begin : g_chk
        a_loop_commit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
            commit[g] |=> data[g] == $past(shreg[g]))
            else $error("Captured slot not stored in buffer");
        a_sti_input: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
            $rose(stat[g]) |-> $past(in_en[g]) && $past(mask[g]) && $past(bclk_rise))
            else $error("Transfer event without enabled input");
        a_stov_output: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
            $rose(stat[4+g]) |-> $past(out_en[g]) && $past(mask[4+g]))
            else $error("Overflow event without enabled output");
        a_stov_cause: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
            $rose(stat[4+g]) |-> $past(|(pend & mask[3:0])) && pend[g] == 1'b0 || !mask[g])
            else $error("Overflow without an unacknowledged transfer event");
        a_input_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
            (!in_en[g] && !wr_en) |=> $stable(data[g]))
            else $error("Buffer changed with input disabled");
    end
endmodule

/* File: tdmsa_cfg.svh */
// Purpose: Constants of the slot access unit (offsets, fields, resets, timing)
// Assumes: 12 slots of 8 bits per frame, 96 bit periods per frame
// Notes:   Byte offsets on the AXI4-Lite register bus
`ifndef TDMSA_CFG_SVH
`define TDMSA_CFG_SVH
`define TDMSA_OFS_DATA0     8'h00
`define TDMSA_OFS_SEL0      8'h10
`define TDMSA_OFS_CTRL0     8'h20
`define TDMSA_OFS_CTRL1     8'h24
`define TDMSA_OFS_MASK      8'h28
`define TDMSA_OFS_ACK       8'h2C
`define TDMSA_OFS_STAT      8'h30
`define TDMSA_OFS_POS       8'h34
`define TDMSA_CTRL_IN0      0
`define TDMSA_CTRL_OUT0     1
`define TDMSA_CTRL_IN1      2
`define TDMSA_CTRL_OUT1     3
`define TDMSA_CTRL_XCH      4
`define TDMSA_CTRL_ARB      5
`define TDMSA_SEL_LINE      7
`define TDMSA_ARB_CODE      4'h8
`define TDMSA_ARB_SLOT      4'hB
`define TDMSA_RST_BYTE      8'hFF
`define TDMSA_RST_ZERO      8'h00
`define TDMSA_FRAME_BITS    96
`define TDMSA_LAST_POS      7'h5F
`define TDMSA_DRC_PER_BIT   2
`endif

/* File: tdmsa_pkg.sv */
// Purpose: Types of the slot access unit
// Assumes: Constants live in tdmsa_cfg.svh
// Notes:   Nothing here holds logic
package tdmsa_pkg;
    typedef logic [7:0] tdmsa_byte_t;
    typedef logic [6:0] tdmsa_pos_t;
    typedef enum logic [1:0] {
        TDMSA_RESP_OKAY   = 2'b00,
        TDMSA_RESP_SLVERR = 2'b10
    } tdmsa_resp_t;
endpackage

/* File: tdmsa_far.sv */
// Purpose: Far end of the serial frame: bit clock, frame sync, line data, capture
// Assumes: Open-drain lines with pull-up, 160 ns bit clock, 96 bits per frame
// Notes:   Idle slots send ones so the wired AND leaves the design's slots intact
`timescale 1ns/1ns
module tdmsa_far (
    // Link timing
    output logic      bit_clock_o,
    output logic      frame_sync_o,
    // Line data
    output logic      up_o,
    output logic      dn_o,
    input  wire logic up_i,
    input  wire logic dn_i
);
    logic [7:0] tx_up [12];
    logic [7:0] tx_dn [12];
    logic [7:0] rx_up [12];
    logic [7:0] rx_dn [12];
    initial begin
        for (int s = 0; s < 12; s++) begin
            tx_up[s] = 8'hFF;
            tx_dn[s] = 8'hFF;
        end
        {bit_clock_o, frame_sync_o, up_o, dn_o} = 4'h3;
        forever for (int p = 0; p < 96; p++) begin
            bit_clock_o = 1'b1;
            up_o = tx_up[p / 8][7 - p % 8];
            dn_o = tx_dn[p / 8][7 - p % 8];
            #80;
            bit_clock_o = 1'b0;
            frame_sync_o = (p == 95) || (p < 3);
            #70;
            // Late in the bit, well clear of the design's update
            rx_up[p / 8][7 - p % 8] = up_i;
            rx_dn[p / 8][7 - p % 8] = dn_i;
            #10;
        end
    end
endmodule

/* File: tdm_slot_access_sync_irq_tb.sv */
// Purpose: Self-checking bench of the slot access unit
// Assumes: Far end model drives the frame; registers reached over AXI4-Lite
// Notes:   Checks are taken at frame sync, after all slots of interest passed
`timescale 1ns/1ns
`include "tdmsa_cfg.svh"
module tdm_slot_access_sync_irq_tb;
    logic                   clk = 1'b0, rst_n = 1'b0;
    logic [7:0]             awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]            wdata = 32'h0, rdata;
    logic                   awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                   arvalid = 1'b0, rready = 1'b0;
    logic                   awready, wready, bvalid, arready, rvalid, irq;
    tdmsa_pkg::tdmsa_resp_t bresp, rresp;
    logic                   bclk, fs, f_up, f_dn, up_o, up_oe_n, dn_o, dn_oe_n, up_w, dn_w;
    int                     errors = 0, num_checks = 0;
    assign up_w = (up_oe_n ? 1'b1 : up_o) & f_up;
    assign dn_w = (dn_oe_n ? 1'b1 : dn_o) & f_dn;
    always #10 clk = ~clk;
    tdmsa_slot_access tdmsa_slot_access_i (.sys_clk_i(clk), .rst_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .bit_clock_i(bclk),
        .frame_sync_i(fs), .upstream_line_i(up_w), .downstream_line_i(dn_w),
        .upstream_line_o(up_o), .upstream_line_oe_n_o(up_oe_n), .downstream_line_o(dn_o),
        .downstream_line_oe_n_o(dn_oe_n), .sync_irq_o(irq));
    tdmsa_far tdmsa_far_i (.bit_clock_o(bclk), .frame_sync_o(fs), .up_o(f_up),
        .dn_o(f_dn), .up_i(up_w), .dn_i(dn_w));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Unmapped or misaligned places answer with an error
    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a > `TDMSA_OFS_POS || a[1:0] != 2'b00) ? 2'b10 : 2'b00;
    endfunction
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 200);
        bready <= 1'b0;
        if (n >= 200) errors++;
        check(bresp, resp_of(a));
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [7:0] e);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 200);
        rready <= 1'b0;
        if (n >= 200) errors++;
        check(rdata, {24'h0, e});
        check(rresp, resp_of(a));
    endtask
    task automatic frames(input int n);
        repeat (n) @(posedge fs);
    endtask
    task automatic t_regs();
        axi_rd(`TDMSA_OFS_DATA0, 8'hFF);
        axi_rd(`TDMSA_OFS_SEL0, 8'h00);
        axi_rd(`TDMSA_OFS_CTRL0, 8'h00);
        axi_rd(8'h40, 8'h00);
        axi_wr(8'h42, 8'h55);
        $display("Test regs done");
    endtask
    task automatic t_loop();
        tdmsa_far_i.tx_up[3] = 8'hA5;
        tdmsa_far_i.tx_dn[6] = 8'h69;
        axi_wr(`TDMSA_OFS_SEL0, 8'h03);
        axi_wr(`TDMSA_OFS_SEL0 + 8'h08, 8'h86);
        axi_wr(`TDMSA_OFS_CTRL0, 8'h03);
        axi_wr(`TDMSA_OFS_CTRL1, 8'h03);
        axi_wr(`TDMSA_OFS_MASK, 8'h01);
        frames(3);
        check(tdmsa_far_i.rx_dn[3], 8'hA5);
        check(tdmsa_far_i.rx_up[6], 8'h69);
        axi_rd(`TDMSA_OFS_STAT, 8'h01);
        tdmsa_far_i.tx_up[3] = 8'h3C;
        axi_wr(`TDMSA_OFS_CTRL0, 8'h02);
        axi_wr(`TDMSA_OFS_STAT, 8'hFF);
        frames(3);
        check(tdmsa_far_i.rx_dn[3], 8'hA5);
        // Frame start lies after the transfer and before the overflow point of slot 3
        axi_wr(`TDMSA_OFS_DATA0, 8'h5C);
        frames(1);
        check(tdmsa_far_i.rx_dn[3], 8'h5C);
        axi_rd(`TDMSA_OFS_STAT, 8'h00);
        axi_wr(`TDMSA_OFS_CTRL0, 8'h03);
        frames(3);
        check(tdmsa_far_i.rx_dn[3], 8'h3C);
        $display("Test loop done");
    endtask
    task automatic t_irq();
        logic [7:0] mk [4] = '{8'h10, 8'h11, 8'h11, 8'h21};
        logic [7:0] ex [4] = '{8'h00, 8'h11, 8'h01, 8'h21};
        axi_wr(`TDMSA_OFS_CTRL0, 8'h0B);
        axi_wr(`TDMSA_OFS_SEL0 + 8'h04, 8'h0C);
        for (int c = 0; c < 4; c++) begin
            frames(1);
            axi_wr(`TDMSA_OFS_MASK, mk[c]);
            axi_wr(`TDMSA_OFS_ACK, 8'h0F);
            axi_wr(`TDMSA_OFS_STAT, 8'hFF);
            repeat (2) begin
                frames(1);
                // Acknowledge well ahead of slot 3
                if (c == 2) axi_wr(`TDMSA_OFS_ACK, 8'h0F);
            end
            axi_rd(`TDMSA_OFS_STAT, ex[c]);
            check(irq, ex[c] != 8'h00);
        end
        $display("Test irq done");
    endtask
    task automatic t_shift();
        tdmsa_far_i.tx_up[2] = 8'h11;
        tdmsa_far_i.tx_up[5] = 8'h33;
        axi_wr(`TDMSA_OFS_MASK, 8'h00);
        axi_wr(`TDMSA_OFS_SEL0, 8'h02);
        axi_wr(`TDMSA_OFS_SEL0 + 8'h04, 8'h05);
        axi_wr(`TDMSA_OFS_CTRL0, 8'h1F);
        frames(3);
        tdmsa_far_i.tx_up[2] = 8'h22;
        tdmsa_far_i.tx_up[5] = 8'h44;
        frames(1);
        check(tdmsa_far_i.rx_dn[5], 8'h22);
        check(tdmsa_far_i.rx_dn[2], 8'h33);
        frames(1);
        check(tdmsa_far_i.rx_dn[2], 8'h44);
        $display("Test shift done");
    endtask
    task automatic t_arb();
        tdmsa_far_i.tx_up[11] = 8'h5A;
        tdmsa_far_i.tx_up[3] = 8'hC3;
        axi_wr(`TDMSA_OFS_SEL0, `TDMSA_ARB_CODE);
        axi_wr(`TDMSA_OFS_SEL0 + 8'h04, 8'h03);
        axi_wr(`TDMSA_OFS_CTRL0, 8'h25);
        frames(2);
        axi_rd(`TDMSA_OFS_DATA0, 8'h5A);
        axi_rd(`TDMSA_OFS_DATA0 + 8'h04, 8'hC3);
        $display("Test arb done");
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        // About 30 frames of work, so 1 ms means a hang
        #1000000;
        errors++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_loop();
        t_irq();
        t_shift();
        t_arb();
        complete_run();
    end
endmodule
